// >>> include/rf_mode_pkg.sv
// constants, types and mode codes of the radio operating-mode controller
`default_nettype none
package rf_mode_pkg;
	////////////////////////////////////////////////////////////////
	// strobe command codes
	localparam logic [7:0] STROBE_DEEP    = 8'h0a;
	localparam logic [7:0] STROBE_IDLE    = 8'h0b;
	localparam logic [7:0] STROBE_LIGHT   = 8'h0c;
	localparam logic [7:0] STROBE_STANDBY = 8'h0d;
	localparam logic [7:0] STROBE_TX      = 8'h0e;
	localparam logic [7:0] STROBE_RX      = 8'h8e;

	typedef enum logic [2:0] {
		MODE_OFF     = 3'h0,
		MODE_DEEP    = 3'h1,
		MODE_LIGHT   = 3'h2,
		MODE_IDLE    = 3'h3,
		MODE_STANDBY = 3'h4,
		MODE_TX      = 3'h5,
		MODE_RX      = 3'h6
	} mode_t;

	// operating mode field bits
	localparam int         OM_ACTIVATE = 2;
	localparam int         OM_DIR_TX   = 1;
	localparam int         OM_SYNTH    = 0;
	localparam logic [2:0] OM_OFF      = 3'h0;

	// pin function-select codes
	localparam logic [2:0] FS12_DATA   = 3'h0;
	localparam logic [2:0] FS12_WAKE   = 3'h1;
	localparam logic [3:0] FS34_BITCLK = 4'h0;
	localparam logic [3:0] FS34_WAKE   = 4'h1;

	////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS  = 4;
	localparam int SETTLE_NS      = 10000;
	localparam int VCO_CAL_433_US = 152;
	localparam int VCO_CAL_868_US = 96;
	localparam int SLOW_CAL_MS    = 4;

	// least time, rounded up, never below one cycle
	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cycles

	localparam int SETTLE_CYCLES      = ns_to_cycles(SETTLE_NS);
	localparam int VCO_CAL_433_CYCLES = ns_to_cycles(VCO_CAL_433_US * 1000);
	localparam int VCO_CAL_868_CYCLES = ns_to_cycles(VCO_CAL_868_US * 1000);
	localparam int SLOW_CAL_CYCLES    = ns_to_cycles(SLOW_CAL_MS * 1000000);
	localparam int TIMER_W            = 20;
	localparam int HALF_BIT_CYCLES    = 16;
	localparam int WAKE_W             = 16;

	////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic retain;
		logic regulator;
		logic xtal;
		logic slowOsc;
		logic synth;
		logic tx;
		logic rx;
	} power_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} pin_drive_t;

	typedef struct packed {
		mode_t             mode;
		logic              pend;
		logic              goTx;
		logic              settled;
		logic              rxSynced;
		logic [WAKE_W-1:0] wakeCnt;
		logic              wakeIrq;
		logic              acal;
		logic              acalRun;
		logic              calDone;
		logic              slowCal;
		logic              slowRun;
		logic              txBit;
		logic              txBitValid;
		logic              rxBit;
		logic              rxBitTaken;
		logic [1:0]        porS;
		logic [2:0]        tickS;
		logic [1:0]        pinS1;
		logic [1:0]        pinS2;
	} ctrl_state_t;
endpackage : rf_mode_pkg
`default_nettype wire

// >>> hw/cycle_timer.sv
// one-shot down counter that pulses done after a loaded count
`timescale 1ns/1ps
`default_nettype none
module cycle_timer
	import rf_mode_pkg::*;
#(
	parameter int W = TIMER_W
) (
	input  wire logic         clk,   // core clock
	input  wire logic         rstN,  // synchronised reset, low active
	input  wire logic         start, // load and run
	input  wire logic [W-1:0] load,  // cycles to run, at least one
	output logic              busy,  // counting
	output logic              done   // one-cycle end pulse
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         busy;
		logic         done;
	} tmr_state_t;

	tmr_state_t st;
	tmr_state_t next_st;

	// restart wins over a run already going
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (start) begin
			next_st.cnt = load;
			next_st.busy = 1'b1;
		end else if (st.busy) begin
			if (st.cnt <= W'(1)) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end else begin
				next_st.cnt = st.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) st <= '0;
		else st <= next_st;
	end

	assign busy = st.busy;
	assign done = st.done;
endmodule : cycle_timer
`default_nettype wire

// >>> hw/bit_clock_gen.sv
// divider that makes the direct-mode bit clock and its edge pulses
`timescale 1ns/1ps
`default_nettype none
module bit_clock_gen
	import rf_mode_pkg::*;
#(
	parameter int HALF = HALF_BIT_CYCLES
) (
	input  wire logic clk,    // core clock
	input  wire logic rstN,   // synchronised reset, low active
	input  wire logic enable, // run the bit clock
	output logic      bitClk, // bit clock level
	output logic      rise,   // pulse with rising edge
	output logic      fall    // pulse with falling edge
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       clk;
		logic       rise;
		logic       fall;
	} bclk_state_t;

	bclk_state_t st;
	bclk_state_t next_st;

	// equal high and low halves; parked low when disabled
	always_comb begin
		next_st = st;
		next_st.rise = 1'b0;
		next_st.fall = 1'b0;
		if (!enable) begin
			next_st.cnt = '0;
			next_st.clk = 1'b0;
			next_st.fall = st.clk;
		end else if (st.cnt == 8'(HALF - 1)) begin
			next_st.cnt = '0;
			next_st.clk = ~st.clk;
			next_st.rise = ~st.clk;
			next_st.fall = st.clk;
		end else begin
			next_st.cnt = st.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) st <= '0;
		else st <= next_st;
	end

	assign bitClk = st.clk;
	assign rise = st.rise;
	assign fall = st.fall;
endmodule : bit_clock_gen
`default_nettype wire

// >>> hw/rf_mode_ctrl.sv
// operating-mode sequencer with wake timer, calibration and direct mode
`timescale 1ns/1ps
`default_nettype none
module rf_mode_ctrl
	import rf_mode_pkg::*;
#(
	parameter int VCO_433_CYCLES  = VCO_CAL_433_CYCLES,
	parameter int VCO_868_CYCLES  = VCO_CAL_868_CYCLES,
	parameter int SLOW_CYCLES     = SLOW_CAL_CYCLES,
	parameter int HALF_BIT        = HALF_BIT_CYCLES
) (
	input  wire logic              clk,                  // core clock
	input  wire logic              nrst,                 // async reset, low
	input  wire logic              porDone,              // power-on reset finished
	input  wire logic              strobeValid,          // strobe pulse
	input  wire logic [7:0]        strobeCode,           // strobe command byte
	input  wire logic              dirEn,                // direct mode select
	input  wire logic [2:0]        operatingModeField,   // direct mode field
	input  wire logic              wakeTimerEnable,      // wake timer run
	input  wire logic [WAKE_W-1:0] wakePeriod,           // slow ticks to wake
	input  wire logic              slowTick,             // slow oscillator
	input  wire logic              autoCalibrationStart, // write-one pulse
	input  wire logic              band868,              // upper band
	input  wire logic              calDoneClear,         // clear done flag
	input  wire logic              slowOscOverride,      // override level
	input  wire logic              slowOscEnable,        // enable level
	input  wire logic              slowOscCalStart,      // write-one pulse
	input  wire logic              eventDone,            // packet event over
	input  wire logic              syncMatch,            // sync word found
	input  wire logic              rxAirBit,             // demodulated bit
	input  wire logic [2:0]        pin1FunctionSelect,   // pin 1 function
	input  wire logic [2:0]        pin2FunctionSelect,   // pin 2 function
	input  wire logic [3:0]        pin3FunctionSelect,   // pin 3 function
	input  wire logic [3:0]        pin4FunctionSelect,   // pin 4 function
	input  wire logic [3:0]        generalPinIn,         // pin levels
	output logic      [3:0]        generalPinOut,        // pin drive value
	output logic      [3:0]        generalPinOe,         // pin drive enable
	output mode_t                  mode,                 // current mode
	output power_t                 power,                // block enables
	output logic                   autoCalBusy,          // auto cal bit
	output logic                   calibrationDoneFlag,  // sticky done
	output logic                   slowCalBusy,          // slow cal bit
	output logic                   txBit,                // direct tx bit
	output logic                   txBitValid,           // tx bit pulse
	output logic                   rxBitTaken,           // rx bit consumed
	output logic                   wakeIrq               // wake request
);
	////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic [1:0] rstPipe;
	logic       rstN;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) rstPipe <= '0;
		else rstPipe <= {rstPipe[0], 1'b1};
	end
	assign rstN = rstPipe[1];

	////////////////////////////////////////////////////////////////
	// helpers
	function automatic power_t mode_power(input mode_t m);
		power_t p;
		p = '0;
		p.retain = (m != MODE_OFF);
		p.regulator = (m == MODE_LIGHT) || (m >= MODE_STANDBY);
		p.xtal = p.regulator;
		p.slowOsc = (m == MODE_IDLE);
		p.synth = (m >= MODE_STANDBY);
		p.tx = (m == MODE_TX);
		p.rx = (m == MODE_RX);
		return p;
	endfunction : mode_power

	// {oe, out} of a data-capable pin
	function automatic logic [1:0] pin12_drive(input logic [2:0] sel,
			input logic dataVal, input logic drv, input logic irq);
		logic [1:0] r;
		r = 2'h0;
		if (sel == FS12_DATA) r = {drv, dataVal & drv};
		else if (sel == FS12_WAKE) r = {1'b1, irq};
		return r;
	endfunction : pin12_drive

	// {oe, out} of a clock-capable pin
	function automatic logic [1:0] pin34_drive(input logic [3:0] sel,
			input logic bclk, input logic drv, input logic irq);
		logic [1:0] r;
		r = 2'h0;
		if (sel == FS34_BITCLK) r = {drv, bclk & drv};
		else if (sel == FS34_WAKE) r = {1'b1, irq};
		return r;
	endfunction : pin34_drive

	////////////////////////////////////////////////////////////////
	// state and sub-blocks
	ctrl_state_t st;
	ctrl_state_t next_st;
	logic        settleStart;
	logic        settleDone;
	logic        vcoStart;
	logic        vcoDone;
	logic        slowStart;
	logic        slowDone;
	logic        bclkEn;
	logic        bitClk;
	logic        bitFall;
	logic        tickEdge;
	logic        dataBit;

	cycle_timer #(.W(TIMER_W)) settleTimer (
		.clk   (clk),
		.rstN  (rstN),
		.start (settleStart),
		.load  (TIMER_W'(SETTLE_CYCLES)),
		.busy  (),
		.done  (settleDone)
	);

	// band picks the budget for the oscillator calibration
	cycle_timer #(.W(TIMER_W)) vcoTimer (
		.clk   (clk),
		.rstN  (rstN),
		.start (vcoStart),
		.load  (band868 ? TIMER_W'(VCO_868_CYCLES) : TIMER_W'(VCO_433_CYCLES)),
		.busy  (),
		.done  (vcoDone)
	);

	cycle_timer #(.W(TIMER_W)) slowTimer (
		.clk   (clk),
		.rstN  (rstN),
		.start (slowStart),
		.load  (TIMER_W'(SLOW_CYCLES)),
		.busy  (),
		.done  (slowDone)
	);

	bit_clock_gen #(.HALF(HALF_BIT)) bitClock (
		.clk    (clk),
		.rstN   (rstN),
		.enable (bclkEn),
		.bitClk (bitClk),
		.rise   (),
		.fall   (bitFall)
	);

	// clock runs in direct send, and in direct receive after sync
	assign bclkEn = dirEn && ((st.mode == MODE_TX) ||
		(st.mode == MODE_RX && st.rxSynced));
	assign tickEdge = st.tickS[1] & ~st.tickS[2];
	// host picks which pin carries the bit
	assign dataBit = (pin2FunctionSelect == FS12_DATA) ? st.pinS2[1] : st.pinS2[0];

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_st = st;
		next_st.txBitValid = 1'b0;
		next_st.rxBitTaken = 1'b0;
		next_st.porS = {st.porS[0], porDone};
		next_st.tickS = {st.tickS[1:0], slowTick};
		next_st.pinS1 = generalPinIn[1:0];
		next_st.pinS2 = st.pinS1;

		// autonomous moves of each mode
		unique case (st.mode)
			MODE_OFF: begin
				if (st.porS[1]) next_st.mode = MODE_DEEP;
			end
			MODE_LIGHT: begin
				if (dirEn && operatingModeField[OM_SYNTH]) begin
					next_st.mode = MODE_STANDBY;
					next_st.pend = 1'b0;
				end
			end
			MODE_STANDBY: begin
				if (dirEn) begin
					if (operatingModeField == OM_OFF) next_st.mode = MODE_LIGHT;
					else if (operatingModeField[OM_ACTIVATE] && st.settled)
						next_st.mode = operatingModeField[OM_DIR_TX] ? MODE_TX : MODE_RX;
				end else if (st.pend && st.settled) begin
					next_st.mode = st.goTx ? MODE_TX : MODE_RX;
					next_st.pend = 1'b0;
				end
			end
			MODE_TX, MODE_RX: begin
				if (dirEn) begin
					if (operatingModeField == OM_OFF) next_st.mode = MODE_LIGHT;
					else if (!operatingModeField[OM_ACTIVATE]) next_st.mode = MODE_STANDBY;
				end else if (eventDone) begin
					next_st.mode = MODE_LIGHT;
				end
			end
			MODE_DEEP, MODE_IDLE: begin
			end
			default: next_st.mode = MODE_OFF;
		endcase

		// strobes override; none taken before power-on reset ends
		if (strobeValid && st.mode != MODE_OFF) begin
			unique case (strobeCode)
				STROBE_DEEP:  next_st.mode = MODE_DEEP;
				STROBE_LIGHT: next_st.mode = MODE_LIGHT;
				STROBE_IDLE:  next_st.mode = MODE_IDLE;
				STROBE_STANDBY: begin
					next_st.mode = MODE_STANDBY;
					next_st.pend = 1'b0;
				end
				STROBE_TX, STROBE_RX: begin
					next_st.mode = MODE_STANDBY;
					next_st.pend = 1'b1;
					next_st.goTx = (strobeCode == STROBE_TX);
				end
				default: begin
				end
			endcase
		end

		// every entry to standby restarts the settling interval
		settleStart = (next_st.mode == MODE_STANDBY) && (st.mode != MODE_STANDBY);
		if (settleStart) next_st.settled = 1'b0;
		else if (settleDone) next_st.settled = 1'b1;

		// wake timer: counts slow ticks only while enabled in idle
		if (st.mode != MODE_IDLE) begin
			next_st.wakeCnt = '0;
			next_st.wakeIrq = 1'b0;
		end else if (wakeTimerEnable && tickEdge && !st.wakeIrq) begin
			if (st.wakeCnt + WAKE_W'(1) >= wakePeriod) next_st.wakeIrq = 1'b1;
			else next_st.wakeCnt = st.wakeCnt + WAKE_W'(1);
		end

		// auto calibration: both parts share one timed run
		if (calDoneClear) next_st.calDone = 1'b0;
		if (autoCalibrationStart) next_st.acal = 1'b1;
		vcoStart = st.acal && !st.acalRun && (st.mode == MODE_LIGHT);
		if (vcoStart) next_st.acalRun = 1'b1;
		if (vcoDone) begin
			next_st.acal = 1'b0;
			next_st.acalRun = 1'b0;
			next_st.calDone = 1'b1;
		end

		// slow calibration waits in light sleep for a valid setup
		if (slowOscCalStart) next_st.slowCal = 1'b1;
		slowStart = st.slowCal && !st.slowRun && (st.mode == MODE_LIGHT) &&
			!slowOscOverride && slowOscEnable;
		if (slowStart) next_st.slowRun = 1'b1;
		if (slowDone) begin
			next_st.slowCal = 1'b0;
			next_st.slowRun = 1'b0;
		end

		// direct bits move on the falling clock edge
		if (st.mode != MODE_RX || !dirEn) next_st.rxSynced = 1'b0;
		else if (syncMatch) next_st.rxSynced = 1'b1;
		if (bitFall && dirEn && st.mode == MODE_TX) begin
			next_st.txBit = dataBit;
			next_st.txBitValid = 1'b1;
		end
		if (bitFall && dirEn && st.mode == MODE_RX) begin
			next_st.rxBit = rxAirBit;
			next_st.rxBitTaken = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) st <= '0;
		else st <= next_st;
	end

	////////////////////////////////////////////////////////////////
	// outputs
	logic rxDrive;
	assign rxDrive = dirEn && (st.mode == MODE_RX);

	always_comb begin
		{generalPinOe[0], generalPinOut[0]} =
			pin12_drive(pin1FunctionSelect, st.rxBit, rxDrive, st.wakeIrq);
		{generalPinOe[1], generalPinOut[1]} =
			pin12_drive(pin2FunctionSelect, st.rxBit, rxDrive, st.wakeIrq);
		{generalPinOe[2], generalPinOut[2]} =
			pin34_drive(pin3FunctionSelect, bitClk, bclkEn, st.wakeIrq);
		{generalPinOe[3], generalPinOut[3]} =
			pin34_drive(pin4FunctionSelect, bitClk, bclkEn, st.wakeIrq);
	end

	assign mode = st.mode;
	assign power = mode_power(st.mode);
	assign autoCalBusy = st.acal;
	assign calibrationDoneFlag = st.calDone;
	assign slowCalBusy = st.slowCal;
	assign txBit = st.txBit;
	assign txBitValid = st.txBitValid;
	assign rxBitTaken = st.rxBitTaken;
	assign wakeIrq = st.wakeIrq;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	a_off_no_retain: assert property (st.mode == MODE_OFF |-> !power.retain && !power.xtal)
		else $error("power down keeps state");
	a_deep_strobe: assert property (strobeValid && strobeCode == STROBE_DEEP &&
		st.mode != MODE_OFF |=> st.mode == MODE_DEEP) else $error("deep strobe missed");
	a_tx_strobe: assert property (strobeValid && strobeCode == STROBE_TX &&
		st.mode == MODE_LIGHT |=> st.mode == MODE_STANDBY && st.pend && st.goTx)
		else $error("tx strobe missed");
	a_por_deep: assert property (st.mode == MODE_OFF && st.porS[1] |=> st.mode == MODE_DEEP)
		else $error("no deep sleep after power-on");
	a_light_power: assert property (st.mode == MODE_LIGHT |-> power.regulator && power.xtal)
		else $error("light sleep without crystal");
	a_tx_settle: assert property ($rose(st.mode == MODE_TX) |->
		$past(st.mode) == MODE_STANDBY && $past(st.settled)) else $error("tx without settling");
	a_event_return: assert property ((st.mode == MODE_TX || st.mode == MODE_RX) && eventDone &&
		!dirEn && !strobeValid |=> st.mode == MODE_LIGHT) else $error("no return to light sleep");
	a_idle_power: assert property (st.mode == MODE_IDLE |->
		!power.regulator && !power.xtal && power.slowOsc) else $error("idle power wrong");
	a_wake_hold: assert property (st.mode == MODE_IDLE && !wakeTimerEnable |=>
		$stable(st.wakeCnt)) else $error("wake timer ran while disabled");
	// irq drops one edge after idle is left, so the previous mode counts too
	a_wake_pin: assert property (st.wakeIrq && pin1FunctionSelect == FS12_WAKE |->
		(st.mode == MODE_IDLE || $past(st.mode) == MODE_IDLE) &&
		generalPinOe[0] && generalPinOut[0]) else $error("wake pin wrong");
	a_tx_sample: assert property (bitFall && dirEn && st.mode == MODE_TX |=>
		txBitValid && txBit == $past(dataBit)) else $error("tx bit not sampled");
	a_rx_wait: assert property (st.mode == MODE_RX && dirEn && !st.rxSynced |-> ##1 !bitClk)
		else $error("rx clock before sync");
	a_cal_done: assert property ($fell(st.acal) |-> st.calDone && $past(vcoDone))
		else $error("calibration end without flag");
	a_slow_clear: assert property ($fell(st.slowCal) |-> $past(slowDone))
		else $error("slow calibration bit cleared early");

	c_tx_reached: cover property (st.mode == MODE_STANDBY && st.goTx ##1 st.mode == MODE_TX);
	c_wake_fired: cover property ($rose(st.wakeIrq));
	c_cal_done: cover property ($rose(st.calDone));
	c_rx_direct: cover property (rxBitTaken && dirEn);
endmodule : rf_mode_ctrl
`default_nettype wire

// >>> verification/host_model.sv
// host side of the direct-mode link: drives tx bits, captures rx bits
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       clk,   // core clock
	input  wire logic       bclk,  // bit clock pin
	input  wire logic       din,   // data wire level
	output logic            dout,  // tx data drive
	output logic [7:0]      sent,  // bits driven
	output logic [7:0]      got,   // bits captured
	output logic [3:0]      hiLen  // last high phase
);
	logic       last = 1'b0;
	logic [3:0] run  = 4'h0;
	logic [7:0] pat  = 8'h4d;
	initial dout = 1'b0;
	initial sent = 8'h00;
	initial got = 8'h00;
	initial hiLen = 4'h0;
	// host only sees the bit clock through its own sampling, like a real mcu
	always @(posedge clk) begin
		last <= bclk;
		run <= (bclk == last) ? run + 4'h1 : 4'h1;
		if (bclk && !last) begin
			pat <= {pat[6:0], pat[7]};
			dout <= pat[7];
			sent <= {sent[6:0], pat[7]};
			got <= {got[6:0], din};
		end
		if (!bclk && last)
			hiLen <= run;
	end
endmodule : host_model
`default_nettype wire

// >>> verification/tb_rf_mode_ctrl.sv
// self-checking bench for the operating-mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_rf_mode_ctrl;
	import rf_mode_pkg::*;
	logic clk = 0, nrst = 0, porDone = 0, strobeValid = 0, dirEn = 0, wakeTimerEnable = 0;
	logic slowTick = 0, autoCalibrationStart = 0, band868 = 0, calDoneClear = 0;
	logic slowOscOverride = 0, slowOscEnable = 1, slowOscCalStart = 0, eventDone = 0;
	logic syncMatch = 0, rxAirBit = 0, txBit, txBitValid, rxBitTaken, hostBit, hold;
	logic autoCalBusy, calibrationDoneFlag, slowCalBusy, wakeIrq;
	logic [7:0] strobeCode = 0, sent, got, txCap = 0, airSent = 0;
	logic [2:0] opField = 3'h0, pin1Sel = 3'h0;
	logic [3:0] pin4Sel = 4'h2;
	logic [15:0] wakePeriod = 16'h0003;
	logic [3:0] generalPinIn, generalPinOut, generalPinOe, hiLen;
	mode_t mode;
	power_t power;
	int failures = 0, samples_checked = 0, n;
	wire dataWire = generalPinOe[0] ? generalPinOut[0] : hostBit;
	assign generalPinIn = {generalPinOut[3:1], dataWire};
	initial forever #2 clk = ~clk;
	// slow oscillator deliberately out of phase with the core clock
	initial #1.3 forever #62.5 slowTick = ~slowTick;
	rf_mode_ctrl #(.VCO_433_CYCLES(40), .VCO_868_CYCLES(30), .SLOW_CYCLES(60), .HALF_BIT(4))
	i_dut (.clk, .nrst, .porDone, .strobeValid, .strobeCode, .dirEn,
		.operatingModeField(opField), .wakeTimerEnable, .wakePeriod, .slowTick,
		.autoCalibrationStart, .band868, .calDoneClear, .slowOscOverride, .slowOscEnable,
		.slowOscCalStart, .eventDone, .syncMatch, .rxAirBit, .pin1FunctionSelect(pin1Sel),
		.pin2FunctionSelect(3'h1), .pin3FunctionSelect(4'h0), .pin4FunctionSelect(pin4Sel),
		.generalPinIn, .generalPinOut, .generalPinOe, .mode, .power, .autoCalBusy,
		.calibrationDoneFlag, .slowCalBusy, .txBit, .txBitValid, .rxBitTaken, .wakeIrq);
	host_model i_host (.clk, .bclk(generalPinOut[2]), .din(dataWire), .dout(hostBit),
		.sent, .got, .hiLen);
	// log device tx samples; new air bit after each one taken
	always @(posedge clk) begin
		if (txBitValid === 1'b1)
			txCap <= {txCap[6:0], txBit};
		if (rxBitTaken === 1'b1) begin
			airSent <= {airSent[6:0], rxAirBit};
			rxAirBit <= ~(airSent[6] ^ airSent[2]);
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic power_t pw(input mode_t m);
		pw = '0;
		pw.retain = (m != MODE_OFF);
		pw.regulator = m inside {MODE_LIGHT, MODE_STANDBY, MODE_TX, MODE_RX};
		pw.xtal = pw.regulator;
		pw.slowOsc = (m == MODE_IDLE);
		pw.synth = m inside {MODE_STANDBY, MODE_TX, MODE_RX};
		pw.tx = (m == MODE_TX);
		pw.rx = (m == MODE_RX);
	endfunction : pw
	task automatic strobe(input logic [7:0] code, input mode_t m);
		@(posedge clk);
		strobeValid <= 1'b1;
		strobeCode <= code;
		@(posedge clk);
		strobeValid <= 1'b0;
		@(negedge clk);
		check("mode", mode, m);
		check("power", power, pw(m));
	endtask : strobe
	// bounded waits, sampled away from the launching edge
	task automatic waitMode(input mode_t m, input int lim);
		for (n = 0; mode !== m && n < lim; n++)
			@(negedge clk);
		check("mode", mode, m);
	endtask : waitMode
	task automatic waitFlag(ref logic s, input logic v, input int lim);
		for (n = 0; s !== v && n < lim; n++)
			@(negedge clk);
	endtask : waitFlag
	////////////////////////////////////////////////////////////////
	task automatic t_event(input logic [7:0] code, input mode_t m);
		strobe(code, MODE_STANDBY);
		waitMode(m, 3000);
		check("settle", n >= SETTLE_CYCLES - 8, 1);
		@(posedge clk);
		eventDone <= 1'b1;
		@(posedge clk);
		eventDone <= 1'b0;
		@(negedge clk);
		check("return", mode, MODE_LIGHT);
	endtask : t_event
	task automatic t_cal(input logic b, input int len);
		@(posedge clk);
		band868 <= b;
		autoCalibrationStart <= 1'b1;
		@(posedge clk);
		autoCalibrationStart <= 1'b0;
		@(negedge clk);
		check("cal busy", autoCalBusy, 1);
		waitFlag(autoCalBusy, 1'b0, 200);
		check("cal time", n >= len && n <= len + 4, 1);
		check("cal flag", calibrationDoneFlag, 1);
		@(posedge clk);
		calDoneClear <= 1'b1;
		@(posedge clk);
		calDoneClear <= 1'b0;
		@(negedge clk);
		check("flag clear", calibrationDoneFlag, 0);
	endtask : t_cal
	// slow calibration stays pending until override is clear and enable set
	task automatic t_slow;
		@(posedge clk);
		slowOscOverride <= 1'b1;
		slowOscCalStart <= 1'b1;
		@(posedge clk);
		slowOscCalStart <= 1'b0;
		repeat (100) @(negedge clk);
		check("slow held", slowCalBusy, 1);
		@(posedge clk);
		slowOscOverride <= 1'b0;
		slowOscEnable <= 1'b0;
		repeat (100) @(negedge clk);
		check("slow held", slowCalBusy, 1);
		@(posedge clk);
		slowOscEnable <= 1'b1;
		waitFlag(slowCalBusy, 1'b0, 200);
		check("slow cal", n >= 60 && n <= 64, 1);
	endtask : t_slow
	task automatic t_wake;
		strobe(8'h0b, MODE_IDLE);
		repeat (200) @(negedge clk);
		check("wake off", wakeIrq, 0);
		@(posedge clk);
		wakeTimerEnable <= 1'b1;
		pin1Sel <= 3'h1;
		pin4Sel <= 4'h1;
		waitFlag(wakeIrq, 1'b1, 300);
		check("wake time", n >= 60 && n <= 104, 1);
		check("wake pin", {generalPinOe[1], generalPinOut[1]}, 2'b11);
		check("wake pin1", {generalPinOe[0], generalPinOut[0]}, 2'b11);
		check("wake pin4", {generalPinOe[3], generalPinOut[3]}, 2'b11);
		strobe(8'h0c, MODE_LIGHT);
		@(negedge clk);
		check("wake drop", wakeIrq, 0);
		@(posedge clk);
		pin1Sel <= 3'h0;
		pin4Sel <= 4'h2;
	endtask : t_wake
	// direct mode: enter through timed standby, then run the link
	task automatic t_direct(input logic tx);
		@(posedge clk);
		dirEn <= 1'b1;
		opField <= {1'b0, tx, 1'b1};
		waitMode(MODE_STANDBY, 4);
		repeat (2600) @(negedge clk);
		hold = 1'b0;
		@(posedge clk);
		opField <= {1'b1, tx, 1'b1};
		waitMode(tx ? MODE_TX : MODE_RX, 4);
		for (int i = 0; i < 40 && !tx; i++)
			@(negedge clk) hold |= generalPinOut[2] | rxBitTaken;
		check("sync wait", hold, 0);
		@(posedge clk);
		syncMatch <= 1'b1;
		repeat (240) @(negedge clk);
		if (tx) begin
			waitFlag(txBitValid, 1'b1, 20);
			@(negedge clk);
			check("tx bits", txCap, sent);
		end else begin
			waitFlag(rxBitTaken, 1'b1, 20);
			repeat (6) @(negedge clk);
			check("rx bits", got, airSent);
		end
		check("half", hiLen, 4);
		@(posedge clk);
		opField <= 3'h0;
		syncMatch <= 1'b0;
		waitMode(MODE_LIGHT, 4);
		@(posedge clk);
		dirEn <= 1'b0;
	endtask : t_direct
	////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	initial begin
		#200000;
		failures++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(negedge clk);
		strobe(8'h0c, MODE_OFF);
		@(posedge clk);
		porDone <= 1'b1;
		waitMode(MODE_DEEP, 8);
		strobe(8'h0c, MODE_LIGHT);
		strobe(8'h0b, MODE_IDLE);
		strobe(8'h0a, MODE_DEEP);
		strobe(8'h0c, MODE_LIGHT);
		strobe(8'h0d, MODE_STANDBY);
		strobe(8'h0c, MODE_LIGHT);
		strobe(8'h55, MODE_LIGHT);
		t_event(8'h0e, MODE_TX);
		t_event(8'h8e, MODE_RX);
		t_cal(1'b0, 40);
		t_cal(1'b1, 30);
		t_slow();
		t_wake();
		t_direct(1'b1);
		t_direct(1'b0);
		complete_run();
	end
endmodule : tb_rf_mode_ctrl
`default_nettype wire
